// ===== design/hbi_clkdiv.sv
/*
  Divides the master clock down to the processor bus rate.
  Gives a clock pin, square for even DIV, and a one-cycle tick on each processor period.
*/
`timescale 1ns/1ps
module hbi_clkdiv #(
  parameter int DIV = hbi_pkg::CPU_DIV
) (
  input wire logic clk,
  input wire logic rst,
  output logic cpu_clk,
  output logic tick
);
  import hbi_pkg::*;

  // the 8-bit counter cannot serve more than 256 steps
  if (DIV < 2 || DIV > 256) begin : g_div_bad
    $error("hbi_clkdiv: DIV must lie between 2 and 256");
  end

  logic [7:0] cnt_reg;
  wire last = (cnt_reg == 8'(DIV - 1));

  // ----------------------------------------
  // counter, tick and clock pin
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      tick <= 1'b0;
      cpu_clk <= 1'b0;
    end else begin
      cnt_reg <= last ? 8'h00 : cnt_reg + 8'h01;
      tick <= last;
      cpu_clk <= (cnt_reg < 8'(DIV / 2));
    end
  end
endmodule

// ===== design/hbi_irq_if.sv
/*
  Bundle between the bus sequencer and the interrupt priority unit.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface hbi_irq_if;
  import hbi_pkg::*;
  logic [IRQ_N-1:0] raw;
  logic ack;
  logic pending;
  logic [2:0] idx;
  modport src (output raw, output ack, input pending, input idx);
  modport prio (input raw, input ack, output pending, output idx);
endinterface

// ===== design/hbi_irq_prio.sv
/*
  Gathers the interrupt sources into sticky pending bits and picks the
  highest-priority one. Sources are levels; a rising level is an event.
*/
`timescale 1ns/1ps
module hbi_irq_prio (
  input wire logic clk,
  input wire logic rst,
  hbi_irq_if.prio irq
);
  import hbi_pkg::*;

  logic [IRQ_N-1:0] prev_reg;
  logic [IRQ_N-1:0] pend_reg;
  logic [2:0] idx_next;
  logic [IRQ_N-1:0] clr;

  // fixed priority: lowest index wins
  always_comb begin
    idx_next = 3'h0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (pend_reg[i]) idx_next = 3'(i);
    end
  end

  assign clr = irq.ack ? (IRQ_N'(1) << irq.idx) : '0;
  wire [IRQ_N-1:0] rise = irq.raw & ~prev_reg;

  // ----------------------------------------
  // sticky pending, a new event beats a same-cycle acknowledge
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= '0;
      pend_reg <= '0;
      irq.pending <= 1'b0;
      irq.idx <= 3'h0;
    end else begin
      prev_reg <= irq.raw;
      pend_reg <= (pend_reg & ~clr) | rise;
      irq.pending <= |((pend_reg & ~clr) | rise);
      irq.idx <= idx_next;
    end
  end
endmodule

// ===== design/hbi_pkg.sv
/*
  Shared constants for the host processor bus interface: clock division,
  I/O decoder layout, control latch fields, interrupt sources, bus states.
  Assumes a single master clock domain and synchronous active-high reset.
*/
package hbi_pkg;

  // ----------------------------------------
  // clocking
  // ----------------------------------------
  localparam int MASTER_HZ = 20_000_000;
  localparam int CPU_HZ = 4_600_000;
  localparam int CPU_DIV = MASTER_HZ / CPU_HZ; // rounds down: never slower than asked

  // ----------------------------------------
  // I/O decoder: addr[7:5] enables, addr[4:2] picks one of eight
  // ----------------------------------------
  localparam logic [2:0] IO_BASE = 3'h0;
  localparam logic [2:0] SEL_LATCH = 3'h3;
  localparam logic [2:0] SEL_DMA = 3'h4;
  localparam logic [2:0] SEL_ROM = 3'h7;

  // ----------------------------------------
  // control latch fields
  // ----------------------------------------
  localparam int INTENS_LSB = 0;
  localparam int INTENS_W = 3;
  localparam int CURSOR_BIT = 3;
  localparam int ATTR_BIT = 4;
  localparam int BELL_BIT = 5;
  localparam int DARK_BIT = 6;
  localparam int SYNC_BIT = 7;
  localparam logic [7:0] LATCH_RST = 8'h00;

  // ----------------------------------------
  // interrupt sources, index 0 is highest priority
  // ----------------------------------------
  localparam int IRQ_N = 5;
  localparam int IRQ_STATUS = 0;
  localparam int IRQ_PORT32 = 1;
  localparam int IRQ_SER_A = 2;
  localparam int IRQ_SER_B = 3;
  localparam int IRQ_KBD = 4;

  // ----------------------------------------
  // bus sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_T1 = 3'b001,
    ST_T2 = 3'b010,
    ST_T3 = 3'b011,
    ST_FLOAT = 3'b100,
    ST_GRANT = 3'b101
  } hbi_state_t;

endpackage

// ===== design/hbi_top.sv
/*
  Host processor bus interface: bus cycle sequencer with strobes, wait,
  bus handover to the display DMA, I/O and memory decode, control latch,
  DMA start address load, interrupt gather and acknowledge.
  Assumes the core side issues one cycle at a time and all inputs are
  synchronous to clk.
*/
// How it works
// - processor bus clock is divided down from the master clock by 4, giving 5 MHz for the 4.6 MHz asked.
// - DMA start address is loaded as two 8-bit I/O writes, low then high.
// - received data on any serial port raises an interrupt request.
// - serial, keyboard and 32-bit port requests are gathered and prioritized.
// - an enabled pending request interrupts the core for the top requester.
// - I/O decoder enabled only during an I/O cycle with valid low address.
// - first-cycle output marks opcode fetch; with I/O strobe it is acknowledge.
// - memory strobe marks a valid memory address and drives the RAM decoder.
// - reset clears interrupt enable, vector, refresh counter and program counter.
// - an I/O write latches intensity, cursor, attribute, bell, dark-on-light, sync.
// - halt and refresh outputs stay idle; all other controls are used.
// - the RAM address is multiplexed to 8 bits, row then column.
// - RAM fills all 64K, so boot ROM is read through I/O and copied.
// - start of the status line interrupts the core for a new DMA start.
`timescale 1ns/1ps
module hbi_top #(
  parameter int DIV = hbi_pkg::CPU_DIV
) (
  input wire logic clk,
  input wire logic rst,
  // core side
  input wire logic core_req,
  input wire logic core_is_io,
  input wire logic core_write,
  input wire logic core_m1,
  input wire logic [15:0] core_addr,
  input wire logic [7:0] core_wdata,
  input wire logic core_ei,
  input wire logic core_di,
  input wire logic core_vec_load,
  input wire logic [7:0] core_vec_value,
  input wire logic core_pc_load,
  input wire logic [15:0] core_pc_value,
  output logic core_done,
  output logic [7:0] core_rdata,
  output logic core_int_pending,
  output logic int_enable,
  output logic [7:0] int_vector,
  output logic [6:0] refresh_count,
  output logic [15:0] pc_value,
  // processor bus pins
  output logic cpu_clk_out,
  output logic [15:0] cpu_address_bus,
  output logic addr_oe_n,
  input wire logic [7:0] cpu_data_in,
  output logic [7:0] cpu_data_bus,
  output logic data_oe_n,
  output logic memory_request_n,
  output logic io_request_n,
  output logic rd_n,
  output logic wr_n,
  output logic ctrl_oe_n,
  output logic first_cycle_n,
  output logic halt_n,
  output logic refresh_out,
  input wire logic wait_n,
  input wire logic bus_request_n,
  output logic bus_grant_n,
  // decode outputs
  output logic [7:0] io_select_n,
  output logic ram_select_n,
  output logic [7:0] ram_addr_mux,
  // control latch
  output logic [2:0] video_intensity_sel,
  output logic cursor_shape_sel,
  output logic logical_attr_display,
  output logic bell_flag,
  output logic dark_on_light,
  output logic sync_clock_select,
  // DMA start address
  output logic [15:0] dma_start_addr,
  output logic dma_addr_load,
  // interrupt sources
  input wire logic serial_a_rx_ready,
  input wire logic serial_b_rx_ready,
  input wire logic kbd_rx_ready,
  input wire logic port32_ready,
  input wire logic status_line_start
);
  import hbi_pkg::*;

  // the divider counter is 8 bits wide
  if (DIV < 2 || DIV > 256) begin : g_div_bad
    $error("hbi_top: DIV must lie between 2 and 256");
  end

  // ----------------------------------------
  // clock division and interrupt gather
  // ----------------------------------------
  logic tick;
  logic cpu_clk;
  hbi_irq_if irq ();

  hbi_clkdiv #(.DIV(DIV)) u_div (
    .clk(clk),
    .rst(rst),
    .cpu_clk(cpu_clk),
    .tick(tick)
  );

  hbi_irq_prio u_prio (
    .clk(clk),
    .rst(rst),
    .irq(irq)
  );

  // source order follows priority, status line first
  assign irq.raw[IRQ_STATUS] = status_line_start;
  assign irq.raw[IRQ_PORT32] = port32_ready;
  assign irq.raw[IRQ_SER_A] = serial_a_rx_ready;
  assign irq.raw[IRQ_SER_B] = serial_b_rx_ready;
  assign irq.raw[IRQ_KBD] = kbd_rx_ready;

  // ----------------------------------------
  // cycle decode
  // ----------------------------------------
  hbi_state_t state_reg;
  hbi_state_t state_next;
  logic [7:0] latch_reg;

  wire busy = (state_reg == ST_T1) || (state_reg == ST_T2);
  // pins stay floated through the release tick so the DMA and the core never overlap
  wire bus_float = (state_next == ST_FLOAT) || (state_next == ST_GRANT) ||
    (state_reg == ST_GRANT);
  wire finish = tick && (state_reg == ST_T2) && wait_n;
  wire int_ack = core_m1 && core_is_io;
  wire io_cycle = core_is_io && !core_m1;
  wire io_dec_en = io_cycle && (core_addr[7:5] == IO_BASE);
  wire [2:0] io_sel = core_addr[4:2];
  wire [7:0] io_onehot = io_dec_en ? (8'h01 << io_sel) : 8'h00;
  wire io_wr_done = finish && core_write && io_dec_en;
  wire latch_we = io_wr_done && (io_sel == SEL_LATCH);
  wire dma_we = io_wr_done && (io_sel == SEL_DMA);
  wire fetch_done = finish && core_m1 && !core_is_io;
  // the whole 64K is RAM; ROM appears only at SEL_ROM for the copy loop
  wire mem_sel = busy && !core_is_io;
  wire [7:0] read_value = int_ack ? {int_vector[7:4], irq.idx, 1'b0} : cpu_data_in;

  // ----------------------------------------
  // sequencer next state; handover only from idle, i.e. between cycles
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (!bus_request_n) state_next = ST_FLOAT;
        else if (core_req) state_next = ST_T1;
      end
      ST_T1: state_next = ST_T2;
      ST_T2: begin
        if (wait_n) state_next = ST_T3;
      end
      ST_T3: state_next = ST_IDLE;
      ST_FLOAT: state_next = ST_GRANT;
      ST_GRANT: begin
        if (bus_request_n) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // state and bus pins, stepping on the processor tick
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      addr_oe_n <= 1'b0;
      ctrl_oe_n <= 1'b0;
      data_oe_n <= 1'b1;
      bus_grant_n <= 1'b1;
    end else if (tick) begin
      state_reg <= state_next;
      // float everything while the DMA owns the bus
      addr_oe_n <= bus_float;
      ctrl_oe_n <= bus_float;
      data_oe_n <= !(((state_next == ST_T1) || (state_next == ST_T2)) && core_write);
      // grant lags the float by one tick so pins are already released
      bus_grant_n <= !(state_next == ST_GRANT && state_reg != ST_IDLE);
    end
  end

  // strobes are asserted across T1 and T2, idle high otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_address_bus <= 16'h0000;
      cpu_data_bus <= 8'h00;
      memory_request_n <= 1'b1;
      io_request_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      first_cycle_n <= 1'b1;
    end else if (tick) begin
      cpu_address_bus <= core_addr;
      cpu_data_bus <= core_wdata;
      memory_request_n <= !(state_next inside {ST_T1, ST_T2} && !core_is_io);
      io_request_n <= !(state_next inside {ST_T1, ST_T2} && core_is_io);
      rd_n <= !(state_next inside {ST_T1, ST_T2} && !core_write && !int_ack);
      wr_n <= !(state_next inside {ST_T1, ST_T2} && core_write);
      first_cycle_n <= !(state_next inside {ST_T1, ST_T2} && core_m1);
    end
  end

  // ----------------------------------------
  // decoders and RAM address multiplexer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      io_select_n <= 8'hff;
      ram_select_n <= 1'b1;
      ram_addr_mux <= 8'h00;
    end else begin
      io_select_n <= busy ? ~io_onehot : 8'hff;
      ram_select_n <= !mem_sel;
      // row in T1, column from T2 on
      ram_addr_mux <= (state_reg == ST_T1) ? core_addr[7:0] : core_addr[15:8];
    end
  end

  // ----------------------------------------
  // core answer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      core_done <= 1'b0;
      core_rdata <= 8'h00;
    end else begin
      core_done <= finish;
      if (finish && !core_write) core_rdata <= read_value;
    end
  end

  // ----------------------------------------
  // control latch and DMA start address
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_reg <= LATCH_RST;
      dma_start_addr <= 16'h0000;
      dma_addr_load <= 1'b0;
    end else begin
      if (latch_we) latch_reg <= core_wdata;
      if (dma_we && !core_addr[0]) dma_start_addr[7:0] <= core_wdata;
      if (dma_we && core_addr[0]) dma_start_addr[15:8] <= core_wdata;
      // high byte completes the pair and lets the DMA run on its own
      dma_addr_load <= dma_we && core_addr[0];
    end
  end

  assign video_intensity_sel = latch_reg[INTENS_LSB +: INTENS_W];
  assign cursor_shape_sel = latch_reg[CURSOR_BIT];
  assign logical_attr_display = latch_reg[ATTR_BIT];
  assign bell_flag = latch_reg[BELL_BIT];
  assign dark_on_light = latch_reg[DARK_BIT];
  assign sync_clock_select = latch_reg[SYNC_BIT];

  // ----------------------------------------
  // core state: interrupt enable, vector, refresh, program counter
  // ----------------------------------------
  assign irq.ack = finish && int_ack;

  always_ff @(posedge clk) begin
    if (rst) begin
      int_enable <= 1'b0;
      int_vector <= 8'h00;
      refresh_count <= 7'h00;
      pc_value <= 16'h0000;
      core_int_pending <= 1'b0;
    end else begin
      // taking an interrupt disables further ones until the core re-enables
      if (irq.ack || core_di) int_enable <= 1'b0;
      else if (core_ei) int_enable <= 1'b1;
      if (core_vec_load) int_vector <= core_vec_value;
      if (fetch_done) refresh_count <= refresh_count + 7'h01;
      if (core_pc_load) pc_value <= core_pc_value;
      else if (fetch_done) pc_value <= pc_value + 16'h0001;
      core_int_pending <= int_enable && irq.pending && !irq.ack;
    end
  end

  // ----------------------------------------
  // unused processor outputs held inactive, clock pin registered
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      halt_n <= 1'b1;
      refresh_out <= 1'b0;
      cpu_clk_out <= 1'b0;
    end else begin
      halt_n <= 1'b1;
      refresh_out <= 1'b0;
      cpu_clk_out <= cpu_clk;
    end
  end

endmodule

// ===== test/hbi_chk.sv
/*
  Port checker for the host bus interface top, bound to hbi_top.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module hbi_chk #(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic addr_oe_n,
  input wire logic ctrl_oe_n,
  input wire logic memory_request_n,
  input wire logic io_request_n,
  input wire logic rd_n,
  input wire logic first_cycle_n,
  input wire logic halt_n,
  input wire logic refresh_out,
  input wire logic [7:0] io_select_n,
  input wire logic ram_select_n,
  input wire logic core_int_pending,
  input wire logic int_enable,
  input wire logic [7:0] int_vector,
  input wire logic [6:0] refresh_count,
  input wire logic [15:0] pc_value,
  input wire logic dma_addr_load
);
  // release is seen on the next tick, plus margin for the register stage
  localparam int REL = DIV + 2;
  // ----------------------------------------
  // bus relations
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_grant_floated: assert property (!bus_grant_n |-> addr_oe_n && ctrl_oe_n)
    else $error("grant given while bus driven");
  a_grant_cause: assert property ($fell(bus_grant_n) |-> $past(!bus_request_n && addr_oe_n))
    else $error("grant without request or float");
  a_grant_release: assert property (bus_request_n && !bus_grant_n |-> ##[1:REL] bus_grant_n)
    else $error("grant held after release");
  a_resume_late: assert property ($rose(bus_grant_n) |-> addr_oe_n)
    else $error("bus driven in release cycle");
  a_spare_idle: assert property (halt_n && !refresh_out)
    else $error("spare outputs active");
  a_ack_no_read: assert property (!first_cycle_n && !io_request_n |-> rd_n)
    else $error("read strobe in acknowledge");
  a_select_onehot: assert property ($onehot0(~io_select_n))
    else $error("more than one device select");
  a_ram_cause: assert property (!ram_select_n |->
      !memory_request_n || $past(!memory_request_n) || $past(!memory_request_n, 2))
    else $error("ram select without memory strobe");
  a_strobe_excl: assert property (memory_request_n || io_request_n)
    else $error("memory and io strobes together");
  a_pend_enabled: assert property (core_int_pending |-> int_enable || $past(int_enable))
    else $error("interrupt while disabled");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> !int_enable && int_vector == 8'h00
      && refresh_count == 7'h00 && pc_value == 16'h0000)
    else $error("state not cleared by reset");
  a_load_pulse: assert property (dma_addr_load |=> !dma_addr_load)
    else $error("start load longer than a pulse");
  // main scenarios reached
  c_grant: cover property ($fell(bus_grant_n));
  c_int_ack: cover property (!first_cycle_n && !io_request_n);
  c_dma_load: cover property (dma_addr_load);
endmodule
bind hbi_top hbi_chk #(.DIV(DIV)) hbi_chk_i (.clk, .rst, .bus_request_n, .bus_grant_n,
  .addr_oe_n, .ctrl_oe_n, .memory_request_n, .io_request_n, .rd_n, .first_cycle_n,
  .halt_n, .refresh_out, .io_select_n, .ram_select_n, .core_int_pending, .int_enable,
  .int_vector, .refresh_count, .pc_value, .dma_addr_load);

// ===== test/hbi_partner.sv
/*
  Far side model: display DMA controller plus memory and a slow device.
  Assumes the design's strobes are registered on the same clock.
*/
`timescale 1ns/1ps
module hbi_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic dma_go,
  input wire logic slow,
  input wire logic rd_n,
  input wire logic memory_request_n,
  input wire logic [15:0] cpu_address_bus,
  input wire logic bus_grant_n,
  input wire logic [15:0] dma_start_addr,
  output logic [7:0] cpu_data_in,
  output logic wait_n,
  output logic bus_request_n
);
  logic [2:0] wait_cnt_reg;
  logic [7:0] last_reg;
  logic [15:0] dma_addr_reg;
  wire logic mem_rd;
  // ----------------------------------------
  // memory answer and wait
  // ----------------------------------------
  assign mem_rd = !rd_n && !memory_request_n;
  // slow mode holds wait for six clocks of each read strobe
  assign wait_n = !(slow && mem_rd && wait_cnt_reg < 3'h6);
  // undriven data toggles so a stale byte never looks valid
  assign cpu_data_in = mem_rd ? (cpu_address_bus[7:0] ^ 8'h5a) : ~last_reg;
  // request line, wait counter and the DMA's own address stepping
  always_ff @(posedge clk) begin
    bus_request_n <= rst || !dma_go;
    wait_cnt_reg <= mem_rd ? wait_cnt_reg + {2'h0, wait_cnt_reg != 3'h7} : 3'h0;
    last_reg <= cpu_data_in;
    dma_addr_reg <= bus_grant_n ? dma_start_addr : dma_addr_reg + 16'h0001;
  end
endmodule

// ===== test/test_host_cpu_bus_interface.sv
/*
  Self-checking bench for hbi_top with the far side model.
  Assumes a 50 ns clock and a short divider so the run stays brief.
*/
`timescale 1ns/1ps
module test_host_cpu_bus_interface;
  import hbi_pkg::*;
  localparam int TDIV = 2;
  logic clk, rst, core_req, core_is_io, core_write, core_m1, dma_go, slow;
  logic [15:0] core_addr, core_pc_value, pc_value, cpu_address_bus, dma_start_addr;
  logic [7:0] core_wdata, core_vec_value, core_rdata, int_vector, io_select_n;
  logic [7:0] ram_addr_mux, cpu_data_in, q, sel_seen;
  logic [3:0] strb;
  logic [4:0] src;
  logic [2:0] video_intensity_sel;
  logic core_done, core_int_pending, int_enable, cpu_clk_out, addr_oe_n, ctrl_oe_n;
  logic memory_request_n, rd_n, wait_n, bus_request_n, bus_grant_n, ram_select_n;
  logic cursor_shape_sel, logical_attr_display, bell_flag, dark_on_light;
  logic sync_clock_select, dma_addr_load, col_seen, load_seen;
  wire logic [7:0] latch_q;
  int n_errors, comparisons, nf, ns;
  realtime t0;
  assign latch_q = {sync_clock_select, dark_on_light, bell_flag, logical_attr_display,
    cursor_shape_sel, video_intensity_sel};
  hbi_top #(.DIV(TDIV)) hbi_top_i (.clk, .rst, .core_req, .core_is_io, .core_write,
    .core_m1, .core_addr, .core_wdata, .core_ei(strb[0]), .core_di(strb[1]),
    .core_vec_load(strb[2]), .core_vec_value, .core_pc_load(strb[3]), .core_pc_value,
    .core_done, .core_rdata, .core_int_pending, .int_enable, .int_vector,
    .refresh_count(), .pc_value, .cpu_clk_out, .cpu_address_bus, .addr_oe_n,
    .cpu_data_in, .cpu_data_bus(), .data_oe_n(), .memory_request_n, .io_request_n(),
    .rd_n, .wr_n(), .ctrl_oe_n, .first_cycle_n(), .halt_n(), .refresh_out(), .wait_n,
    .bus_request_n, .bus_grant_n, .io_select_n, .ram_select_n, .ram_addr_mux,
    .video_intensity_sel, .cursor_shape_sel, .logical_attr_display, .bell_flag,
    .dark_on_light, .sync_clock_select, .dma_start_addr, .dma_addr_load,
    .serial_a_rx_ready(src[2]), .serial_b_rx_ready(src[3]), .kbd_rx_ready(src[4]),
    .port32_ready(src[1]), .status_line_start(src[0]));
  hbi_partner hbi_partner_i (.clk, .rst, .dma_go, .slow, .rd_n, .memory_request_n,
    .cpu_address_bus, .bus_grant_n, .dma_start_addr, .cpu_data_in, .wait_n, .bus_request_n);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one core cycle; inputs held until the done pulse, clocks counted
  task automatic bus(input logic io, wr, m1, input logic [15:0] a, input logic [7:0] d,
      output logic [7:0] r, output int n);
    n = 0;
    @(posedge clk);
    core_req <= 1'b1;
    core_is_io <= io;
    core_write <= wr;
    core_m1 <= m1;
    core_addr <= a;
    core_wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (core_done !== 1'b1 && n < 200);
    if (core_done !== 1'b1) n_errors++;
    core_req <= 1'b0;
    r = core_rdata;
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    strb <= m;
    @(posedge clk);
    strb <= 4'h0;
    // one more edge so the strobe's effect has settled before any compare
    @(posedge clk);
  endtask
  // sticky record of decoder activity, checked after the latch, DMA and fetch cycles
  always @(posedge clk) begin
    if (io_select_n !== 8'hff) sel_seen <= io_select_n;
    if (ram_select_n === 1'b0 && ram_addr_mux === 8'h12) col_seen <= 1'b1;
    if (dma_addr_load === 1'b1) load_seen <= 1'b1;
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard, far beyond the few hundred clocks the tests need
  initial begin
    #1000000;
    n_errors++;
    report_and_stop();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {rst, core_req, core_is_io, core_write, core_m1, dma_go, slow} = 7'h40;
    {core_addr, core_wdata, strb, src, col_seen, load_seen, sel_seen} = '0;
    core_vec_value = 8'ha5;
    core_pc_value = 16'hbeef;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset_state", {int_enable, bus_grant_n, latch_q}, {2'b01, LATCH_RST});
    @(posedge cpu_clk_out);
    t0 = $realtime;
    @(posedge cpu_clk_out);
    chk("cpu_clk_period", 16'(int'(($realtime - t0) / 50.0)), 16'(TDIV));
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 1'b1, 1'b0, 16'h000c, k ? 8'h4a : 8'hb5, q, nf);
      chk("latch", latch_q, k ? 8'h4a : 8'hb5);
    end
    chk("latch_select", sel_seen, 8'hf7);
    bus(1'b1, 1'b1, 1'b0, 16'h0010, 8'h34, q, nf);
    bus(1'b1, 1'b1, 1'b0, 16'h0011, 8'h12, q, nf);
    chk("dma_start", dma_start_addr, 16'h1234);
    @(posedge clk);
    chk("dma_load_sel", {load_seen, sel_seen}, 9'h1ef);
    bus(1'b0, 1'b0, 1'b1, 16'h1234, 8'h00, q, nf);
    chk("fetch_data", {col_seen, q}, 9'h16e);
    slow <= 1'b1;
    bus(1'b0, 1'b0, 1'b0, 16'h00ff, 8'h00, q, ns);
    slow <= 1'b0;
    chk("slow_read", {ns > nf, q}, 9'h1a5);
    pulse(4'b0100);
    for (int i = 0; i < 7; i++) begin
      pulse(4'b0001);
      if (i < 5) src[i] <= 1'b1;
      if (i == 5) src <= 5'b01010;
      repeat (4) @(posedge clk);
      chk("pending", core_int_pending, 1'b1);
      bus(1'b1, 1'b0, 1'b1, 16'h0000, 8'h00, q, nf);
      repeat (2) @(posedge clk);
      chk("ack_vector", q, 8'ha0 | 8'(i < 5 ? i * 2 : i * 4 - 18));
      chk("ack_disables", int_enable, 1'b0);
      if (i != 5) src <= 5'b00000;
    end
    pulse(4'b0001);
    pulse(4'b0010);
    chk("disable", {int_enable, int_vector}, 9'h0a5);
    @(posedge clk);
    dma_go <= 1'b1;
    fork
      bus(1'b0, 1'b0, 1'b0, 16'h0042, 8'h00, q, nf);
      begin
        repeat (12) @(posedge clk);
        chk("granted", {bus_grant_n, addr_oe_n, ctrl_oe_n, memory_request_n}, 4'h7);
        dma_go <= 1'b0;
      end
    join
    chk("after_release", {addr_oe_n, q}, 9'h018);
    pulse(4'b1000);
    chk("pc_load", pc_value, 16'hbeef);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("pc_reset", {pc_value, int_vector}, 24'h0);
    report_and_stop();
  end
endmodule
